//--- core/sram_array.sv
// Byte-writable storage array with a registered read port
`timescale 1ns/100ps
`include "sram_ctrl_cfg.svh"
module sram_array (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // Access
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic i_we,
  input wire logic [`BYTE_N-1:0] i_byte_we,
  input wire logic [`DATA_W-1:0] i_wdata,
  output logic [`DATA_W-1:0] o_rdata
);

  logic [`DATA_W-1:0] mem_r [0:(1<<`ADDR_W)-1];

  // ----------------------------------------------------------------------
  // Write: unselected bytes keep their contents
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    for (int b = 0; b < `BYTE_N; b++) begin
      if (i_we && i_byte_we[b]) begin
        mem_r[i_addr][b*`BYTE_W +: `BYTE_W] <= i_wdata[b*`BYTE_W +: `BYTE_W];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= `DATA_RST;
    end else begin
      o_rdata <= mem_r[i_addr];
    end
  end

endmodule : sram_array

//--- core/sync_burst_sram_sleep_ctrl.sv
// Control of a pipelined synchronous burst SRAM with sleep mode
`timescale 1ns/100ps
`include "sram_ctrl_cfg.svh"
module sync_burst_sram_sleep_ctrl (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // Address and strobes
  input wire logic [`ADDR_W-1:0] i_addr,
  input wire logic i_processor_addr_strobe_n,
  input wire logic i_controller_addr_strobe_n,
  input wire logic i_burst_advance_n,
  input wire logic i_burst_order_interleaved,
  // Chip selects
  input wire logic i_chip_select_first_n,
  input wire logic i_chip_select_second,
  input wire logic i_chip_select_third_n,
  // Write controls
  input wire logic i_global_write_n,
  input wire logic i_byte_write_enable_n,
  input wire logic [`BYTE_N-1:0] i_byte_select_n,
  // Data pins
  input wire logic [`DATA_W-1:0] i_dq,
  output logic [`DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  input wire logic i_output_enable_n,
  // Sleep
  input wire logic i_sleep_request,
  output logic o_sleep_active
);
  import sram_ctrl_pkg::*;

  localparam int c_sleep_cyc = `SLEEP_ENTRY_CYC;

  logic [2:0] sleep_sync_r;
  logic sleep_r;
  logic active_r;
  logic rd_pend_r;
  logic drive_r;
  logic wr_r;
  logic [`ADDR_W-1:`BURST_W] hi_r;
  logic [`BURST_W-1:0] base_r;
  logic [`BURST_W-1:0] step_r;
  logic [`DATA_W-1:0] dq_r;
  logic [`DATA_W-1:0] rdata;

  // ----------------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------------
  wire logic selected = ~i_chip_select_first_n & i_chip_select_second &
                        ~i_chip_select_third_n;
  wire logic ps_start = ~i_processor_addr_strobe_n & ~i_chip_select_first_n;
  wire logic strobe = ps_start | ~i_controller_addr_strobe_n;
  wire logic wr_q = ~i_global_write_n |
                    (~i_byte_write_enable_n & ~(&i_byte_select_n));
  wire logic [`BYTE_N-1:0] byte_we = ~i_global_write_n ? {`BYTE_N{1'b1}} :
                                     ~i_byte_select_n;

  cyc_t kind;
  // a selected processor start outside sleep is always a read
  assign kind = sleep_r ? CYC_SLEEP :
                strobe ? (!selected ? CYC_DESEL :
                          (ps_start || !wr_q) ? CYC_RD_BEGIN : CYC_WR_BEGIN) :
                !active_r ? CYC_IDLE :
                i_burst_advance_n ? CYC_SUSPEND : CYC_CONTINUE;

  wire logic load = (kind == CYC_RD_BEGIN) || (kind == CYC_WR_BEGIN);
  wire logic burst = (kind == CYC_CONTINUE) || (kind == CYC_SUSPEND);
  // writes only on a controller start or inside a started burst
  wire logic is_write = (kind == CYC_WR_BEGIN) || (burst && wr_q);
  wire logic is_read = (kind == CYC_RD_BEGIN) || (burst && !wr_q);

  // ----------------------------------------------------------------------
  // Burst address
  // ----------------------------------------------------------------------
  wire logic [`ADDR_W-1:`BURST_W] hi_nxt = load ?
                                  i_addr[`ADDR_W-1:`BURST_W] : hi_r;
  wire logic [`BURST_W-1:0] base_nxt = load ?
                            i_addr[`BURST_MSB:`BURST_LSB] : base_r;
  wire logic [`BURST_W-1:0] step_nxt = load ? `BURST_RST :
                            (kind == CYC_CONTINUE) ?
                            `BURST_W'(step_r + 2'h1) : step_r;
  wire logic [`BURST_W-1:0] low_nxt = i_burst_order_interleaved ?
                            (base_nxt ^ step_nxt) :
                            `BURST_W'(base_nxt + step_nxt);
  wire logic [`ADDR_W-1:0] addr_nxt = {hi_nxt, low_nxt};

  // ----------------------------------------------------------------------
  // Sleep synchroniser
  // ----------------------------------------------------------------------
  // asynchronous request passes three flops
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sleep_sync_r <= `SYNC_RST;
    end else begin
      sleep_sync_r <= {sleep_sync_r[1:0], i_sleep_request};
    end
  end

  // state follows once the last two stages agree
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sleep_r <= 1'b0;
    end else if (sleep_sync_r[1] == sleep_sync_r[2]) begin
      sleep_r <= sleep_sync_r[2];
    end
  end

  // ----------------------------------------------------------------------
  // Access state
  // ----------------------------------------------------------------------
  // sleep abandons any open burst
  wire logic active_nxt = load ? 1'b1 :
                          ((kind == CYC_DESEL) || (kind == CYC_SLEEP)) ?
                          1'b0 : active_r;
  // first cycle of a read stays floating
  wire logic drive_nxt = rd_pend_r && is_read;

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      active_r <= 1'b0;
      rd_pend_r <= 1'b0;
      drive_r <= 1'b0;
      wr_r <= 1'b0;
      hi_r <= '0;
      base_r <= `BURST_RST;
      step_r <= `BURST_RST;
      dq_r <= `DATA_RST;
    end else begin
      active_r <= active_nxt;
      rd_pend_r <= is_read;
      drive_r <= drive_nxt;
      wr_r <= is_write;
      hi_r <= hi_nxt;
      base_r <= base_nxt;
      step_r <= step_nxt;
      dq_r <= rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------------
  // no writes reach the array while asleep
  sram_array u_array (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_addr(addr_nxt),
    .i_we(is_write),
    .i_byte_we(byte_we),
    .i_wdata(i_dq),
    .o_rdata(rdata)
  );

  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  // cycle type and output enable decide the drive
  // output enable gates the drivers without a register
  // output enable has no effect while writing
  // read with enable low drives all bits
  // Gated after the flop on purpose: the pin enable must follow OE at once
  assign o_dq_oe = drive_r & ~wr_r & ~i_output_enable_n;
  assign o_dq = dq_r;
  assign o_sleep_active = sleep_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  sequence s_req_settled;
    sleep_sync_r[1] && sleep_sync_r[2] && !sleep_r;
  endsequence
  sequence s_fresh_read;
    !active_r && !sleep_r && strobe && selected && (ps_start || !wr_q);
  endsequence
  sequence s_step;
    !sleep_r && !strobe && active_r && !i_burst_advance_n;
  endsequence

  a_sleep_entry: assert property (
    s_req_settled |-> ##[1:c_sleep_cyc] sleep_r)
    else $error("sleep not entered in time");
  a_sleep_float: assert property (
    sleep_r |=> !o_dq_oe && !active_r)
    else $error("pins driven or burst open during sleep");
  a_sleep_nowrite: assert property (
    sleep_r |-> !is_write)
    else $error("array written while asleep");
  a_processor_addr_strobe_n_read: assert property (
    (!sleep_r && ps_start && selected) |=> !wr_r ##1 !wr_r || active_r)
    else $error("processor start treated as write");
  a_first_float: assert property (
    s_fresh_read |=> !o_dq_oe)
    else $error("outputs driven in first read cycle");
  a_burst_step: assert property (
    s_step |=> step_r == `BURST_W'($past(step_r) + 2'h1))
    else $error("burst counter did not advance");
  a_burst_hold: assert property (
    (!sleep_r && !strobe && active_r && i_burst_advance_n)
    |=> $stable(step_r) && $stable(base_r))
    else $error("suspend changed burst address");
  a_linear_order: assert property (
    (!i_burst_order_interleaved && kind == CYC_CONTINUE)
    |-> addr_nxt[`BURST_MSB:`BURST_LSB] ==
        `BURST_W'($past(addr_nxt[`BURST_MSB:`BURST_LSB]) + 2'h1))
    else $error("linear burst order wrong");
  a_write_mask: assert property (
    wr_r |-> !o_dq_oe && !drive_r)
    else $error("pins driven during write");
  a_desel_float: assert property (
    (!sleep_r && strobe && !selected) |=> !active_r ##1 !o_dq_oe)
    else $error("deselect left outputs driven");

endmodule : sync_burst_sram_sleep_ctrl

//--- inc/sram_ctrl_cfg.svh
// Widths, field positions, reset values and timing counts of the SRAM core
`ifndef SRAM_CTRL_CFG_SVH
`define SRAM_CTRL_CFG_SVH

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define ADDR_W 15
`define DATA_W 36
`define BYTE_N 4
`define BYTE_W 9
`define BURST_W 2
`define BURST_LSB 0
`define BURST_MSB 1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DATA_RST 36'h0_0000_0000
`define BURST_RST 2'h0
`define SYNC_RST 3'h0

// ----------------------------------------------------------------------
// Sleep timing: two clock periods to enter and to leave
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define SLEEP_ENTRY_TIME_NS 200
`define SLEEP_RECOVERY_TIME_NS 200
`define SLEEP_ENTRY_CYC (`SLEEP_ENTRY_TIME_NS / `CLK_PERIOD_NS)
`define SLEEP_RECOVERY_CYC (`SLEEP_RECOVERY_TIME_NS / `CLK_PERIOD_NS)

`endif

//--- inc/sram_ctrl_pkg.sv
// Types shared by the burst SRAM control logic
package sram_ctrl_pkg;

  // ----------------------------------------------------------------------
  // Kind of the cycle decided at a clock edge
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    CYC_IDLE     = 3'b000,
    CYC_DESEL    = 3'b001,
    CYC_RD_BEGIN = 3'b010,
    CYC_WR_BEGIN = 3'b011,
    CYC_CONTINUE = 3'b100,
    CYC_SUSPEND  = 3'b101,
    CYC_SLEEP    = 3'b110
  } cyc_t;

endpackage : sram_ctrl_pkg

//--- test/sram_bus_ctl_model.sv
// Bus controller model driving the SRAM control and data lines
`timescale 1ns/100ps
`include "sram_ctrl_cfg.svh"
module sram_bus_ctl_model (
  // Clock
  input wire logic i_clk_sys,
  // Strobes {proc, ctrl, adv}, selects {first_n, second, third_n}
  output logic [2:0] o_strb_n,
  output logic [2:0] o_sel,
  // Writes {global_n, byte_en_n, byte_sel_n[3:0]}, enable, sleep
  output logic [5:0] o_wr_n,
  output logic o_oe_n,
  output logic o_sleep,
  // Address and write data
  output logic [`ADDR_W-1:0] o_addr,
  output logic [`DATA_W-1:0] o_dq
);
  initial begin
    o_strb_n = 3'h7;
    o_sel = 3'h5;
    o_wr_n = 6'h3f;
    o_oe_n = 1'h1;
    o_sleep = 1'h0;
    o_addr = 15'h0000;
    o_dq = 36'h0_0000_0000;
  end
  // Called at a rising edge; the device takes it at the next one
  task automatic drive(input logic [2:0] s, input logic [2:0] c,
      input logic [5:0] w, input logic oe, input logic [`ADDR_W-1:0] a,
      input logic [`DATA_W-1:0] d);
    o_strb_n <= s;
    o_sel <= c;
    o_wr_n <= w;
    o_oe_n <= oe;
    o_addr <= a;
    // Released lines must not keep showing the last word
    o_dq <= (&w) ? ~o_dq : d;
  endtask : drive
  task automatic set_oe(input logic v);
    o_oe_n = v;
  endtask : set_oe
  task automatic sleep_on();
    drive(3'h5, 3'h5, 6'h3f, 1'h1, o_addr, o_dq);
    @(posedge i_clk_sys);
    drive(3'h7, 3'h5, 6'h3f, 1'h1, o_addr, o_dq);
    #30 o_sleep = 1'h1;
    @(posedge i_clk_sys);
  endtask : sleep_on
  task automatic sleep_off();
    #30 o_sleep = 1'h0;
    repeat (2) @(posedge i_clk_sys);
  endtask : sleep_off
endmodule : sram_bus_ctl_model

//--- test/sync_burst_sram_sleep_ctrl_bench.sv
// Self-checking bench for the burst SRAM control block
`timescale 1ns/100ps
`include "sram_ctrl_cfg.svh"
module sync_burst_sram_sleep_ctrl_bench;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic ilv = 1'h0;
  logic [2:0] strb_n, sel;
  logic [5:0] wr_n;
  logic oe_n, sleep_req, dq_oe, sleep_act;
  logic [`ADDR_W-1:0] addr;
  logic [`DATA_W-1:0] ctl_dq, dut_dq, dq_w;
  logic [`DATA_W-1:0] mem [4];
  logic [8:0] salt;
  int n_fail = 0;
  int n_tests = 0;
  int n_cyc = 0;
  assign dq_w = dq_oe ? dut_dq : ctl_dq;
  always #50 clk = ~clk;
  sram_bus_ctl_model i_ctl (.i_clk_sys(clk), .o_strb_n(strb_n),
    .o_sel(sel), .o_wr_n(wr_n), .o_oe_n(oe_n), .o_sleep(sleep_req),
    .o_addr(addr), .o_dq(ctl_dq));
  sync_burst_sram_sleep_ctrl i_dut (.i_clk_sys(clk), .i_arst_n(arst_n),
    .i_addr(addr), .i_processor_addr_strobe_n(strb_n[2]),
    .i_controller_addr_strobe_n(strb_n[1]), .i_burst_advance_n(strb_n[0]),
    .i_burst_order_interleaved(ilv), .i_chip_select_first_n(sel[2]),
    .i_chip_select_second(sel[1]), .i_chip_select_third_n(sel[0]),
    .i_global_write_n(wr_n[5]), .i_byte_write_enable_n(wr_n[4]),
    .i_byte_select_n(wr_n[3:0]), .i_dq(dq_w), .o_dq(dut_dq),
    .o_dq_oe(dq_oe), .i_output_enable_n(oe_n),
    .i_sleep_request(sleep_req), .o_sleep_active(sleep_act));
  // ----
  // Helpers
  // ----
  function automatic logic [`DATA_W-1:0] wd(input logic [3:0] a);
    return {salt, 5'h00, a, salt, ~salt};
  endfunction : wd
  function automatic logic [3:0] ad(input int i, input int k);
    return i ? 4'(1 ^ k) : 4'((1 + k) % 4);
  endfunction : ad
  task automatic cmp(input string what, input logic [`DATA_W-1:0] exp,
      input logic [`DATA_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : cmp
  // One bus cycle; the checks look at what the previous edge produced
  task automatic cyc(input logic [2:0] s, input logic [2:0] c,
      input logic [5:0] w, input logic oe, input logic [3:0] a,
      input logic [1:0] m, input logic [`DATA_W-1:0] e, input logic eoe);
    i_ctl.drive(s, c, w, oe, (s[2] & s[1]) ? 15'h7fff : {11'h004, a},
      wd(a));
    @(negedge clk);
    if (m[0]) cmp("read data", e, dut_dq);
    if (m[1]) cmp("drive enable", eoe, dq_oe);
    @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [2:0] s, input logic [5:0] w,
      input logic oe, input logic [3:0] a);
    logic [`DATA_W-1:0] d;
    cyc(s, 3'h2, w, oe, a, 2'h2, '0, 1'h0);
    d = wd(a);
    for (int b = 0; b < `BYTE_N; b++)
      if (!w[5] || (!w[4] && !w[b]))
        mem[a][b*`BYTE_W +: `BYTE_W] = d[b*`BYTE_W +: `BYTE_W];
  endtask : wr
  task automatic oe_blip();
    #30 i_ctl.set_oe(1'h1);
    #1 cmp("drive enable", 1'h0, dq_oe);
    i_ctl.set_oe(1'h0);
    #1 cmp("drive enable", 1'h1, dq_oe);
    @(posedge clk);
  endtask : oe_blip
  task automatic wait_sleep(input logic v);
    int n;
    n = 0;
    while (sleep_act !== v && n < 5) begin
      @(negedge clk);
      n++;
    end
    cmp("sleep state", v, sleep_act);
    @(posedge clk);
  endtask : wait_sleep
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    n_cyc++;
    if (n_cyc == 400) begin
      n_fail++;
      finish_test();
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    salt = 9'h0a5;
    repeat (12) @(posedge clk);
    arst_n <= 1'h1;
    @(posedge clk);
    // Output enable kept high at the start of the write burst, low on its continued writes
    wr(3'h5, 6'h1f, 1'h1, 4'h0);
    for (int k = 1; k < 4; k++)
      wr(3'h6, 6'h1f, 1'h0, 4'(k));
    // Suspended write lands on the last burst address again
    salt = 9'h055;
    wr(3'h7, 6'h1f, 1'h0, 4'h3);
    salt = 9'h13c;
    cyc(3'h3, 3'h2, 6'h1f, 1'h1, 4'h3, 2'h2, '0, 1'h0);
    wr(3'h6, 6'h1f, 1'h1, 4'h0);
    salt = 9'h0f0;
    wr(3'h5, 6'h2d, 1'h1, 4'h2);
    wr(3'h5, 6'h2f, 1'h1, 4'h1);
    wr(3'h5, 6'h30, 1'h1, 4'h1);
    salt = 9'h1ff;
    for (int i = 0; i < 2; i++) begin
      ilv <= 1'(i);
      cyc(3'h5, 3'h5, 6'h3f, 1'h1, 4'h0, 2'h2, '0, 1'h0);
      cyc(3'h3, 3'h2, 6'h1f, 1'h0, ad(i, 0), 2'h0, '0, 1'h0);
      cyc(3'h6, 3'h2, 6'h3f, 1'h0, ad(i, 1), 2'h2, '0, 1'h0);
      cyc(3'h2, 3'h5, 6'h3f, 1'h0, ad(i, 2), 2'h1, mem[ad(i, 0)],
        1'h0);
      cyc(3'h6, 3'h2, 6'h3f, 1'h0, ad(i, 3), 2'h3, mem[ad(i, 1)],
        1'h1);
      cyc(3'h7, 3'h2, 6'h3f, 1'h0, ad(i, 3), 2'h3, mem[ad(i, 2)],
        1'h1);
      oe_blip();
      cyc(i ? 3'h3 : 3'h5, i ? 3'h3 : 3'h5, 6'h3f, 1'h0, 4'h0, 2'h3,
        mem[ad(i, 3)], 1'h1);
      cyc(3'h7, 3'h5, 6'h3f, 1'h0, 4'h0, 2'h2, '0, 1'h0);
    end
    ilv <= 1'h0;
    i_ctl.sleep_on();
    wait_sleep(1'h1);
    cyc(3'h5, 3'h2, 6'h1f, 1'h0, 4'h0, 2'h2, '0, 1'h0);
    cyc(3'h7, 3'h5, 6'h3f, 1'h0, 4'h0, 2'h2, '0, 1'h0);
    i_ctl.sleep_off();
    wait_sleep(1'h0);
    cyc(3'h3, 3'h2, 6'h3f, 1'h0, 4'h0, 2'h0, '0, 1'h0);
    cyc(3'h6, 3'h2, 6'h3f, 1'h0, 4'h1, 2'h0, '0, 1'h0);
    cyc(3'h5, 3'h5, 6'h3f, 1'h0, 4'h0, 2'h1, mem[0], 1'h0);
    finish_test();
  end
endmodule : sync_burst_sram_sleep_ctrl_bench
